/* File: hw/mcu_instruction_decode.sv */
// Instruction decode and four-phase execution sequencer of the core
//
// Behaviour
// [RULE_01] Every instruction is one 14-bit word: opcode plus operand fields.
// [RULE_02] Each word falls into exactly one group: byte, bit, or literal/control.
// [RULE_03] Byte operations store to accumulator when d is 0, else to the file register.
// [RULE_04] The register locator is a seven-bit direct address, 0x00 to 0x7F.
// [RULE_05] Bit operations pick one bit of the 8-bit register by position field.
// [RULE_06] Literal operations take an 8-bit data or 11-bit jump constant.
// [RULE_07] A working accumulator is implicit operand and possible destination.
// [RULE_08] One instruction cycle spans four clock periods; all timing in whole cycles.
// [RULE_09] One cycle per instruction; two when a skip is taken or jump occurs.
// [RULE_10] Named file registers are read, modified, and stored to the chosen target.
// [RULE_11] The named register is read even by write-only instructions like clear.
// [RULE_12] Don't-care opcode bits do not change the operation executed.
// [RULE_13] On jump or taken skip the prefetched word is replaced by a no-op.
`default_nettype none
module mcu_instruction_decode (
  input  wire logic                              i_clock,
  input  wire logic                              i_rstn,
  input  wire logic [mcu_core_pkg::INSTR_W-1:0]  i_instr,
  output logic      [mcu_core_pkg::PC_W-1:0]     o_program_counter,
  output logic      [mcu_core_pkg::DATA_W-1:0]   o_accumulator,
  output logic                                   o_carry,
  output logic                                   o_nibble_overflow_flag,
  output logic                                   o_zero,
  output logic                                   o_watchdog_expiry_flag,
  output logic                                   o_sleep_entry_flag,
  output mcu_core_pkg::group_e                   o_group,
  output logic                                   o_cycle_start,
  output logic                                   o_nop_slot,
  output logic                                   o_file_read,
  output logic                                   o_file_write,
  output logic      [mcu_core_pkg::FADDR_W-1:0]  o_file_addr,
  output logic      [mcu_core_pkg::DATA_W-1:0]   o_file_wdata,
  output logic                                   o_sleep_req,
  output logic                                   o_wdt_clear
);
  import mcu_core_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  phase_e              phase_reg;
  logic [INSTR_W-1:0]  ir_reg;
  logic [PC_W-1:0]     pc_reg;
  logic [DATA_W-1:0]   w_reg;
  logic                carry_reg;
  logic                nibble_reg;
  logic                zero_reg;
  logic                expiry_reg;
  logic                sleep_reg;
  group_e              group_reg;
  logic                cycle_start_reg;
  logic                flush_reg;
  logic                jump_reg;
  logic [PC_W-1:0]     target_reg;
  logic                nop_slot_reg;
  logic                file_rd_reg;
  logic                file_wr_reg;
  logic [FADDR_W-1:0]  file_addr_reg;
  logic [DATA_W-1:0]   file_wdata_reg;
  logic                sleep_req_reg;
  logic                wdt_clear_reg;
  logic [PC_W-1:0]     stack_reg [STACK_DEPTH];
  logic [SP_W-1:0]     sp_reg;

  // ----------------------------------------
  // Decode of the word in execution
  // ----------------------------------------
  group_e              grp;
  alu_op_e             op;
  logic                dest_file;
  logic                uses_file;
  logic                is_jump;
  logic                is_call;
  logic                is_return;
  logic                is_retlw;
  logic                lit_move;
  logic                skip_cond;
  logic [DATA_W-1:0]   file_rdata;
  logic [DATA_W-1:0]   alu_a;
  logic [DATA_W-1:0]   alu_result;
  logic                alu_carry;
  logic                alu_nibble;
  logic                alu_zero;
  logic                upd_z;
  logic                upd_c;
  logic                upd_dc;
  logic [SP_W-1:0]     sp_prev;

  // [RULE_02] group classification
  assign grp       = group_of(ir_reg);
  // [RULE_12] masked opcode match
  assign op        = alu_op_of(ir_reg);
  // [RULE_03] result target select
  assign dest_file = (grp == GRP_BIT) ? (op != OP_BTST) :
                     (grp == GRP_BYTE) && ir_reg[DEST_POS];
  // [RULE_11] read even for write-only ops
  assign uses_file = (grp != GRP_LIT);
  assign is_jump   = (ir_reg[13:12] == 2'b10);
  assign is_call   = is_jump && !ir_reg[CALL_POS];
  assign is_retlw  = (ir_reg[13:10] == 4'b1101);
  assign is_return = is_retlw || (ir_reg == CTL_RETURN) || (ir_reg == CTL_RETFIE);
  assign lit_move  = (grp == GRP_LIT) && (op == OP_MOV);
  assign sp_prev   = sp_reg - 3'h1;

  // [RULE_06] eight-bit literal operand
  assign alu_a = (grp == GRP_LIT) ? ir_reg[DATA_W-1:0] : file_rdata;

  // [RULE_05] bit test on selected position
  always_comb begin
    skip_cond = 1'b0;
    if (op == OP_BTST) begin
      skip_cond = (file_rdata[ir_reg[BIT_LO +: BIT_W]] == ir_reg[TEST_POS]);
    end else if ((grp == GRP_BYTE) && (ir_reg[11:8] == 4'hb || ir_reg[11:8] == 4'hf)) begin
      skip_cond = alu_zero;
    end
  end

  core_alu u_alu (
    .i_op     (op),
    .i_a      (alu_a),
    .i_w      (w_reg),
    .i_carry  (carry_reg),
    .i_bit    (ir_reg[BIT_LO +: BIT_W]),
    .o_result (alu_result),
    .o_carry  (alu_carry),
    .o_nibble (alu_nibble),
    .o_zero   (alu_zero),
    .o_upd_z  (upd_z),
    .o_upd_c  (upd_c),
    .o_upd_dc (upd_dc)
  );

  file_ram u_ram (
    .i_clock (i_clock),
    .i_rd_en (file_rd_reg),
    .i_wr_en (file_wr_reg),
    .i_addr  (file_addr_reg),
    .i_wdata (file_wdata_reg),
    .o_rdata (file_rdata)
  );

  // ----------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------
  // [RULE_08] four clocks per instruction cycle
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_reg       <= PH_Q1;
      cycle_start_reg <= 1'b0;
    end else begin
      unique case (phase_reg)
        PH_Q1: phase_reg <= PH_Q2;
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        PH_Q4: phase_reg <= PH_Q1;
      endcase
      cycle_start_reg <= (phase_reg == PH_Q4);
    end
  end

  // ----------------------------------------
  // Fetch and program counter
  // ----------------------------------------
  // Next word is fetched while the current one runs; it is sampled at cycle end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ir_reg       <= NOP_WORD;
      pc_reg       <= PC_RESET;
      nop_slot_reg <= 1'b0;
    end else if (phase_reg == PH_Q4) begin
      // [RULE_01] whole word latched
      // [RULE_13] discard prefetched word
      ir_reg       <= flush_reg ? NOP_WORD : i_instr;
      nop_slot_reg <= flush_reg;
      pc_reg       <= jump_reg ? target_reg : pc_reg + 13'h0001;
    end
  end

  // ----------------------------------------
  // File register access
  // ----------------------------------------
  // [RULE_10] read in Q2, write back in Q4
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      file_rd_reg    <= 1'b0;
      file_wr_reg    <= 1'b0;
      file_addr_reg  <= '0;
      file_wdata_reg <= '0;
      group_reg      <= GRP_LIT;
    end else begin
      file_rd_reg <= (phase_reg == PH_Q1) && uses_file;
      file_wr_reg <= (phase_reg == PH_Q3) && dest_file;
      if (phase_reg == PH_Q1) begin
        // [RULE_04] seven-bit direct locator
        file_addr_reg <= ir_reg[FADDR_W-1:0];
        group_reg     <= grp;
      end
      if (phase_reg == PH_Q3) begin
        file_wdata_reg <= alu_result;
      end
    end
  end

  // ----------------------------------------
  // Accumulator and status flags
  // ----------------------------------------
  // [RULE_07] accumulator as destination
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      w_reg      <= W_RESET;
      carry_reg  <= 1'b0;
      nibble_reg <= 1'b0;
      zero_reg   <= 1'b0;
    end else if (phase_reg == PH_Q3) begin
      // [RULE_03] d = 0 lands in accumulator
      if (!dest_file && op != OP_NONE && op != OP_BTST) begin
        w_reg <= alu_result;
      end
      // Literal moves and skip forms leave zero untouched
      if (upd_z && !lit_move && !skip_cond && ir_reg[11:8] != 4'hb
          && !(grp == GRP_BYTE && ir_reg[11:8] == 4'hf)) begin
        zero_reg <= alu_zero;
      end
      if (upd_c) begin
        carry_reg <= alu_carry;
      end
      if (upd_dc) begin
        nibble_reg <= alu_nibble;
      end
    end
  end

  // ----------------------------------------
  // Power and watchdog control words
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      expiry_reg    <= EXPIRY_RST;
      sleep_reg     <= SLEEP_RST;
      sleep_req_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
    end else begin
      sleep_req_reg <= (phase_reg == PH_Q3) && (ir_reg == CTL_SLEEP);
      wdt_clear_reg <= (phase_reg == PH_Q3)
                       && ((ir_reg == CTL_SLEEP) || (ir_reg == CTL_CLRWDT));
      if (phase_reg == PH_Q3 && ir_reg == CTL_CLRWDT) begin
        expiry_reg <= 1'b1;
        sleep_reg  <= 1'b1;
      end else if (phase_reg == PH_Q3 && ir_reg == CTL_SLEEP) begin
        expiry_reg <= 1'b1;
        sleep_reg  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Branch, skip and return stack
  // ----------------------------------------
  // [RULE_09] second cycle runs as a no-op
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flush_reg  <= 1'b0;
      jump_reg   <= 1'b0;
      target_reg <= PC_RESET;
    end else if (phase_reg == PH_Q3) begin
      flush_reg <= skip_cond || is_jump || is_return;
      jump_reg  <= is_jump || is_return;
      // [RULE_06] eleven-bit jump target
      target_reg <= is_return ? stack_reg[sp_prev]
                              : {pc_reg[PC_W-1:KJMP_W], ir_reg[KJMP_W-1:0]};
    end
  end

  // Stack wraps silently on overflow; no error is flagged
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sp_reg <= '0;
    end else if (phase_reg == PH_Q3) begin
      if (is_call) begin
        sp_reg <= sp_reg + 3'h1;
      end else if (is_return) begin
        sp_reg <= sp_prev;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (phase_reg == PH_Q3 && is_call) begin
      stack_reg[sp_reg] <= pc_reg;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_program_counter      = pc_reg;
  assign o_accumulator          = w_reg;
  assign o_carry                = carry_reg;
  assign o_nibble_overflow_flag = nibble_reg;
  assign o_zero                 = zero_reg;
  assign o_watchdog_expiry_flag = expiry_reg;
  assign o_sleep_entry_flag     = sleep_reg;
  assign o_group                = group_reg;
  assign o_cycle_start          = cycle_start_reg;
  assign o_nop_slot             = nop_slot_reg;
  assign o_file_read            = file_rd_reg;
  assign o_file_write           = file_wr_reg;
  assign o_file_addr            = file_addr_reg;
  assign o_file_wdata           = file_wdata_reg;
  assign o_sleep_req            = sleep_req_reg;
  assign o_wdt_clear            = wdt_clear_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cycle_four_phases: assert property ( // [RULE_08]
    @(posedge i_clock) disable iff (!i_rstn)
    o_cycle_start |-> ##4 o_cycle_start)
    else $error("instruction cycle is not four clocks");

  a_fetch_once: assert property ( // [RULE_01]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q4 && !flush_reg) |=> (ir_reg == $past(i_instr)))
    else $error("fetched word not taken whole");

  a_read_before_write: assert property ( // [RULE_10]
    @(posedge i_clock) disable iff (!i_rstn)
    o_file_write |-> ($past(o_file_read, 2) && $stable(o_file_addr)))
    else $error("file write without prior read");

  a_clear_reads: assert property ( // [RULE_11]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q1 && ir_reg[13:8] == 6'h01) |=> o_file_read)
    else $error("clear skipped its read");

  a_locator_field: assert property ( // [RULE_04]
    @(posedge i_clock) disable iff (!i_rstn)
    o_file_read |-> (o_file_addr == ir_reg[6:0]))
    else $error("file address differs from locator field");

  a_dest_accum: assert property ( // [RULE_03]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q3 && grp == GRP_BYTE && !ir_reg[7])
    |=> (!o_file_write && o_accumulator == $past(alu_result)))
    else $error("d = 0 result not in accumulator");

  a_bit_set: assert property ( // [RULE_05]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q3 && ir_reg[13:10] == 4'b0101)
    |=> (o_file_wdata == ($past(file_rdata) | (8'h01 << $past(ir_reg[9:7])))))
    else $error("bit set wrote wrong value");

  a_literal_move: assert property ( // [RULE_07]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q3 && ir_reg[13:10] == 4'b1100)
    |=> (o_accumulator == $past(ir_reg[7:0])))
    else $error("literal not moved to accumulator");

  a_jump_nop_slot: assert property ( // [RULE_13]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q3 && ir_reg[13:12] == 2'b10)
    |-> ##2 (ir_reg == NOP_WORD && o_nop_slot
             && o_program_counter == {$past(pc_reg[12:11], 2),
                                      $past(ir_reg[10:0], 2)}))
    else $error("jump did not load target with no-op slot");

  a_single_cycle: assert property ( // [RULE_09]
    @(posedge i_clock) disable iff (!i_rstn)
    (phase_reg == PH_Q3 && grp == GRP_BYTE && ir_reg[11:8] == 4'h7)
    |-> ##2 !o_nop_slot)
    else $error("plain instruction took an extra cycle");
endmodule // mcu_instruction_decode
`default_nettype wire

/* File: pkg/mcu_core_pkg.sv */
// Shared constants, types and decode functions for the instruction core
`default_nettype none
package mcu_core_pkg;

  // ----------------------------------------
  // Widths and depths
  // ----------------------------------------
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int PC_W        = 13;
  localparam int KJMP_W      = 11;
  localparam int BIT_W       = 3;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int FILE_DEPTH  = 128;

  // ----------------------------------------
  // Field positions in the instruction word
  // ----------------------------------------
  localparam int DEST_POS = 7;
  localparam int BIT_LO   = 7;
  localparam int TEST_POS = 10;
  localparam int CALL_POS = 11;

  // ----------------------------------------
  // Fixed words and reset values
  // ----------------------------------------
  localparam logic [INSTR_W-1:0] NOP_WORD    = 14'h0000;
  localparam logic [INSTR_W-1:0] CTL_RETURN  = 14'h0008;
  localparam logic [INSTR_W-1:0] CTL_RETFIE  = 14'h0009;
  localparam logic [INSTR_W-1:0] CTL_SLEEP   = 14'h0063;
  localparam logic [INSTR_W-1:0] CTL_CLRWDT  = 14'h0064;
  localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
  localparam logic [DATA_W-1:0]  W_RESET     = 8'h00;
  localparam logic               EXPIRY_RST  = 1'b1;
  localparam logic               SLEEP_RST   = 1'b1;

  typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT} group_e;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
  typedef enum logic [4:0] {
    OP_NONE, OP_MOVW, OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR, OP_ADD,
    OP_MOV, OP_COM, OP_INC, OP_RRF, OP_RLF, OP_SWAP, OP_BCF, OP_BSF, OP_BTST
  } alu_op_e;

  // Control words share the byte space with d = 0 below opcode 0001
  function automatic group_e group_of(input logic [INSTR_W-1:0] w);
    casez (w[13:7])
      7'b01?????: group_of = GRP_BIT;
      7'b1??????: group_of = GRP_LIT;
      7'b0000000: group_of = GRP_LIT;
      default:    group_of = GRP_BYTE;
    endcase
  endfunction

  function automatic alu_op_e alu_op_of(input logic [INSTR_W-1:0] w);
    casez (w[13:8])
      6'b000000: alu_op_of = w[DEST_POS] ? OP_MOVW : OP_NONE;
      6'b000001: alu_op_of = OP_CLR;
      6'b000010: alu_op_of = OP_SUB;
      6'b000011: alu_op_of = OP_DEC;
      6'b000100: alu_op_of = OP_IOR;
      6'b000101: alu_op_of = OP_AND;
      6'b000110: alu_op_of = OP_XOR;
      6'b000111: alu_op_of = OP_ADD;
      6'b001000: alu_op_of = OP_MOV;
      6'b001001: alu_op_of = OP_COM;
      6'b00101?: alu_op_of = w[8] ? OP_DEC : OP_INC;
      6'b001100: alu_op_of = OP_RRF;
      6'b001101: alu_op_of = OP_RLF;
      6'b001110: alu_op_of = OP_SWAP;
      6'b001111: alu_op_of = OP_INC;
      6'b0100??: alu_op_of = OP_BCF;
      6'b0101??: alu_op_of = OP_BSF;
      6'b011???: alu_op_of = OP_BTST;
      6'b1100??: alu_op_of = OP_MOV;
      6'b1101??: alu_op_of = OP_MOV;
      6'b111000: alu_op_of = OP_IOR;
      6'b111001: alu_op_of = OP_AND;
      6'b111010: alu_op_of = OP_XOR;
      6'b11110?: alu_op_of = OP_SUB;
      6'b11111?: alu_op_of = OP_ADD;
      default:   alu_op_of = OP_NONE;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: hw/file_ram.sv */
// File register storage with registered read data
`default_nettype none
module file_ram (
  input  wire logic                              i_clock,
  input  wire logic                              i_rd_en,
  input  wire logic                              i_wr_en,
  input  wire logic [mcu_core_pkg::FADDR_W-1:0]  i_addr,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   i_wdata,
  output logic      [mcu_core_pkg::DATA_W-1:0]   o_rdata
);
  import mcu_core_pkg::*;

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  always_ff @(posedge i_clock) begin
    if (i_rd_en) begin
      o_rdata <= mem[i_addr];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule // file_ram
`default_nettype wire

/* File: hw/core_alu.sv */
// Combinational arithmetic and logic unit of the core
`default_nettype none
module core_alu (
  input  wire mcu_core_pkg::alu_op_e             i_op,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   i_a,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   i_w,
  input  wire logic                              i_carry,
  input  wire logic [mcu_core_pkg::BIT_W-1:0]    i_bit,
  output logic      [mcu_core_pkg::DATA_W-1:0]   o_result,
  output logic                                   o_carry,
  output logic                                   o_nibble,
  output logic                                   o_zero,
  output logic                                   o_upd_z,
  output logic                                   o_upd_c,
  output logic                                   o_upd_dc
);
  import mcu_core_pkg::*;

  logic [DATA_W:0]   sum;
  logic [4:0]        nib;
  logic [DATA_W-1:0] mask;

  assign mask   = 8'h01 << i_bit;
  assign o_zero = (o_result == 8'h00);

  always_comb begin
    o_result = i_a;
    o_carry  = i_carry;
    o_nibble = 1'b0;
    o_upd_z  = 1'b1;
    o_upd_c  = 1'b0;
    o_upd_dc = 1'b0;
    sum      = {1'b0, i_a} + {1'b0, i_w};
    nib      = {1'b0, i_a[3:0]} + {1'b0, i_w[3:0]};
    unique case (i_op)
      OP_NONE: o_upd_z = 1'b0;
      OP_MOVW: begin
        o_result = i_w;
        o_upd_z  = 1'b0;
      end
      OP_CLR:  o_result = 8'h00;
      OP_ADD: begin
        o_result = sum[DATA_W-1:0];
        o_carry  = sum[DATA_W];
        o_nibble = nib[4];
        o_upd_c  = 1'b1;
        o_upd_dc = 1'b1;
      end
      OP_SUB: begin
        // Carry reads as no-borrow
        sum      = {1'b0, i_a} - {1'b0, i_w};
        nib      = {1'b0, i_a[3:0]} - {1'b0, i_w[3:0]};
        o_result = sum[DATA_W-1:0];
        o_carry  = ~sum[DATA_W];
        o_nibble = ~nib[4];
        o_upd_c  = 1'b1;
        o_upd_dc = 1'b1;
      end
      OP_DEC:  o_result = i_a - 8'h01;
      OP_INC:  o_result = i_a + 8'h01;
      OP_IOR:  o_result = i_a | i_w;
      OP_AND:  o_result = i_a & i_w;
      OP_XOR:  o_result = i_a ^ i_w;
      OP_MOV:  o_result = i_a;
      OP_COM:  o_result = ~i_a;
      OP_RRF: begin
        o_result = {i_carry, i_a[7:1]};
        o_carry  = i_a[0];
        o_upd_z  = 1'b0;
        o_upd_c  = 1'b1;
      end
      OP_RLF: begin
        o_result = {i_a[6:0], i_carry};
        o_carry  = i_a[7];
        o_upd_z  = 1'b0;
        o_upd_c  = 1'b1;
      end
      OP_SWAP: begin
        o_result = {i_a[3:0], i_a[7:4]};
        o_upd_z  = 1'b0;
      end
      OP_BCF: begin
        o_result = i_a & ~mask;
        o_upd_z  = 1'b0;
      end
      OP_BSF: begin
        o_result = i_a | mask;
        o_upd_z  = 1'b0;
      end
      OP_BTST: o_upd_z = 1'b0;
    endcase
  end
endmodule // core_alu
`default_nettype wire

/* File: tb/mcu_instruction_decode_tb.sv */
// Self-checking bench for the instruction decode core
`default_nettype none
module mcu_instruction_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcu_core_pkg::*;
  // ----------------------------------------
  // Design and probes
  // ----------------------------------------
  logic                 i_clock, i_rstn;
  logic [INSTR_W-1:0]   i_instr;
  logic [PC_W-1:0]      pc;
  logic [DATA_W-1:0]    acc, wdata, wr_data;
  logic [FADDR_W-1:0]   faddr, wr_addr;
  logic                 c, dc, z, expiry, slp, cs, nop, rd, wr, sreq, wclr;
  group_e               grp;
  logic                 rd_seen, wr_seen, nop_seen, slp_seen, wclr_seen;
  logic [3:0]           cs_pat;
  int                   errors, n_checks, cycles;

  mcu_instruction_decode i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_instr(i_instr),
    .o_program_counter(pc), .o_accumulator(acc), .o_carry(c),
    .o_nibble_overflow_flag(dc), .o_zero(z), .o_watchdog_expiry_flag(expiry),
    .o_sleep_entry_flag(slp), .o_group(grp), .o_cycle_start(cs), .o_nop_slot(nop),
    .o_file_read(rd), .o_file_write(wr), .o_file_addr(faddr), .o_file_wdata(wdata),
    .o_sleep_req(sreq), .o_wdt_clear(wclr));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // Hang guard: the whole program needs about 120 clocks
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Presents one word for a whole cycle; probes describe the word fed one call earlier
  task automatic feed(input logic [INSTR_W-1:0] w);
    i_instr = w;
    {rd_seen, wr_seen, nop_seen, slp_seen, wclr_seen} = 5'h00;
    for (int i = 0; i < 4; i++) begin
      cs_pat[i] = cs;
      rd_seen |= rd;
      nop_seen |= nop;
      slp_seen |= sreq;
      wclr_seen |= wclr;
      if (wr === 1'b1) begin
        wr_seen = 1'b1;
        wr_addr = faddr;
        wr_data = wdata;
      end
      @(posedge i_clock);
      #1;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_literal();
    logic [PC_W-1:0] p0;
    p0 = pc;
    feed(14'h305a);
    feed(14'h3e10);
    check("acc movlw", 16'(acc), 16'h005a);
    check("cycle start", 16'(cs_pat), 16'h0001);
    feed(14'h3f01);
    check("acc addlw", 16'(acc), 16'h006a);
    feed(14'h0000);
    check("acc addlw x1", 16'(acc), 16'h006b);
    check("group lit", 16'(grp), 16'(GRP_LIT));
    check("pc step", 16'(pc), 16'(p0 + 13'h0004));
    $display("test literal done");
  endtask

  task automatic t_byte();
    feed(14'h00ff);
    feed(14'h0100);
    check("movwf write", 16'({wr_seen, rd_seen}), 16'h0003);
    check("movwf addr", 16'(wr_addr), 16'h007f);
    check("movwf data", 16'(wr_data), 16'h006b);
    check("group byte", 16'(grp), 16'(GRP_BYTE));
    feed(14'h087f);
    check("clrw acc", 16'(acc), 16'h0000);
    check("clrw zero", 16'(z), 16'h0001);
    feed(14'h0000);
    check("movf d0 no write", 16'({wr_seen, rd_seen}), 16'h0001);
    check("movf acc", 16'(acc), 16'h006b);
    check("movf zero", 16'(z), 16'h0000);
    $display("test byte done");
  endtask

  task automatic t_bits();
    feed(14'h01ff);
    feed(14'h17ff);
    check("clrf read", 16'(rd_seen), 16'h0001);
    check("clrf data", 16'(wr_data), 16'h0000);
    feed(14'h087f);
    check("bsf data", 16'(wr_data), 16'h0080);
    check("group bit", 16'(grp), 16'(GRP_BIT));
    feed(14'h0000);
    check("bit acc", 16'(acc), 16'h0080);
    $display("test bits done");
  endtask

  task automatic t_skip();
    feed(14'h1fff);
    feed(14'h3011);
    check("btfss no write", 16'(wr_seen), 16'h0000);
    feed(14'h0000);
    check("skip nop slot", 16'(nop_seen), 16'h0001);
    check("skip acc kept", 16'(acc), 16'h0080);
    feed(14'h2923);
    feed(14'h3022);
    feed(14'h0000);
    check("jump nop slot", 16'(nop_seen), 16'h0001);
    check("jump acc kept", 16'(acc), 16'h0080);
    check("jump pc", 16'(pc), 16'h0124);
    $display("test skip done");
  endtask

  task automatic t_sleep();
    feed(14'h0063);
    feed(14'h0064);
    check("sleep flags", 16'({slp, expiry, slp_seen, wclr_seen}), 16'h0007);
    feed(14'h3c80);
    check("clrwdt flags", 16'({slp, expiry, slp_seen, wclr_seen}), 16'h000d);
    feed(14'h077f);
    check("sublw acc", 16'(acc), 16'h0000);
    check("sublw flags", 16'({c, dc, z}), 16'h0007);
    feed(14'h0000);
    check("addwf acc", 16'(acc), 16'h0080);
    check("addwf flags", 16'({c, dc, z}), 16'h0000);
    $display("test sleep done");
  endtask

  task automatic t_call();
    logic [PC_W-1:0] ret;
    ret = pc + 13'h0001;
    feed(14'h2200);
    feed(14'h3fff);
    check("call pc", 16'(pc), 16'h0200);
    feed(14'h3433);
    feed(14'h3fff);
    feed(14'h0000);
    check("retlw acc", 16'(acc), 16'h0033);
    check("return pc", 16'(pc), 16'(ret + 13'h0001));
    $display("test call done");
  endtask

  initial begin
    {i_rstn, i_instr, errors, n_checks, cycles} = '0;
    repeat (10) @(posedge i_clock);
    #1;
    check("reset pc acc", 16'({pc, 3'h0} | 16'(acc)), 16'h0000);
    check("reset flags", 16'({expiry, slp, grp}), 16'(8 + 4 + GRP_LIT));
    i_rstn = 1'b1;
    t_literal();
    t_byte();
    t_bits();
    t_skip();
    t_sleep();
    t_call();
    tally_and_finish();
  end
endmodule // mcu_instruction_decode_tb
`default_nettype wire
